//--- lsl_glass_model.sv
// Purpose: passive model of the row electrodes on the glass
// Assumes: one row is driven per clock
// Notes: reports the last frame's length, first row and first line
`timescale 1ns/1ps
module lsl_glass_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // row drive
  input wire logic [6:0] drive_row_q,
  input wire logic [6:0] ram_line_q,
  input wire logic [6:0] mra_n_q,
  input wire logic frame_start_q,
  // observations
  output logic [7:0] frame_len,
  output logic [6:0] first_row,
  output logic [6:0] first_line,
  output int bad_cnt
);
  logic [7:0] cnt_q;
  logic [6:0] prev_q;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_q <= 8'h00;
      frame_len <= 8'h00;
      first_row <= 7'h00;
      first_line <= 7'h00;
      bad_cnt <= 0;
    end else if (frame_start_q) begin
      frame_len <= cnt_q;
      cnt_q <= 8'h01;
      first_row <= drive_row_q;
      first_line <= ram_line_q;
    end else begin
      cnt_q <= cnt_q + 8'h01;
      // a mode change mid-frame also counts, so the bench compares deltas
      if (cnt_q != 8'h00 && ram_line_q !== 7'((prev_q + 7'h01) % mra_n_q)) begin
        bad_cnt <= bad_cnt + 1;
      end
    end
    prev_q <= ram_line_q;
  end
endmodule

//--- lsl_pkg.sv
// Purpose: shared constants for the start line and bias selection block
// Assumes: 32-bit APB register bus, one word per register
// Notes: mux code k selects a multiplex rate of 1:(16 + 8k) while the icon row is off
package lsl_pkg;
  // register byte offsets
  localparam logic [7:0] LSL_OFS_START = 8'h00;
  localparam logic [7:0] LSL_OFS_IROW = 8'h04;
  localparam logic [7:0] LSL_OFS_MODE = 8'h08;
  localparam logic [7:0] LSL_OFS_STAT = 8'h0C;
  localparam logic [7:0] LSL_OFS_SCAN = 8'h10;
  // mode register fields
  localparam int LSL_MODE_MUX_LSB = 0;
  localparam int LSL_MODE_ICON_BIT = 4;
  localparam int LSL_MODE_EXT_BIT = 5;
  localparam int LSL_MODE_MPEN_BIT = 6;
  localparam int LSL_MODE_MPSEL_BIT = 7;
  // status register fields
  localparam int LSL_STAT_P_LSB = 0;
  localparam int LSL_STAT_M_LSB = 4;
  localparam int LSL_STAT_N_LSB = 11;
  localparam int LSL_STAT_ERR_LSB = 24;
  // scan register fields
  localparam int LSL_SCAN_ROW_LSB = 0;
  localparam int LSL_SCAN_LINE_LSB = 8;
  // reset values
  localparam logic [6:0] LSL_RST_START = 7'h00;
  localparam logic [6:0] LSL_RST_IROW = 7'h00;
  localparam logic [3:0] LSL_RST_MUX = 4'h8;
  // limits and steps
  localparam logic [3:0] LSL_MUX_MAX = 4'h8;
  localparam logic [3:0] LSL_MUX_FULL_LO = 4'h6;
  localparam logic [6:0] LSL_LINE_BANNED = 7'h48;
  localparam logic [6:0] LSL_ICON_ROW = 7'h4F;
  localparam logic [6:0] LSL_STEP8_MASK = 7'h78;
  localparam logic [6:0] LSL_STEP16_MASK = 7'h70;
  localparam int LSL_MOD_ITER = 13;
endpackage

//--- lsl_start_bias.sv
// Purpose: maps display RAM lines onto driven rows and picks p, m and N per multiplex rate
// Assumes: APB slave with one wait-free access; scan advances one row per clock
// Notes: no RAM lives here; only the line-to-row mapping is produced
`timescale 1ns/1ps

// Summary of operation
// - first driven row shows the RAM line chosen by the start line value
// - without icon row the start line moves in steps of eight at rates 1:64 to 1:80
// - with icon row enabled the start line moves in steps of sixteen
// - partial display modes also restrict the start line to coarse steps
// - initial row selects first driven row; never the icon row when enabled
// - start line or initial row changes alter mapping only, never RAM
// - several rows are selected at once; p reaches eight at top rates
// - bias variables are chosen automatically for each display mode
// - without icon row p and m follow the per-rate table
// - with icon row N, m and p follow the icon table
// - icon row only usable while the extended command set is active
// - manual p honoured only at rates 1:64 and 1:80
// - start line and initial row are zero after reset
module lsl_start_bias (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // row driver side
  output logic [6:0] drive_row_q,
  output logic [6:0] ram_line_q,
  output logic frame_start_q,
  output logic icon_on_q,
  output logic [3:0] mra_p_q,
  output logic [6:0] mra_m_q,
  output logic [6:0] mra_n_q
);
  import lsl_pkg::*;

  logic [6:0] start_q;
  logic [6:0] irow_q;
  logic [3:0] mux_q;
  logic icon_req_q;
  logic ext_q;
  logic mp_en_q;
  logic mp_sel_q;
  logic [2:0] err_q;
  logic [6:0] scan_k_q;
  logic [6:0] l_mod_q;
  logic [6:0] c_mod_q;
  logic icon_eff;
  logic [6:0] step_mask;
  logic [3:0] p_d;
  logic [6:0] m_d;
  logic [6:0] n_d;
  logic wr_en;
  logic rd_setup;
  logic [6:0] wdat_l;
  logic [3:0] wdat_mux;
  logic wdat_icon;
  logic start_bad;
  logic irow_bad;
  logic mode_bad;
  logic mapped;
  logic [31:0] rd_d;

  // repeated subtraction keeps the modulo cheap; n is never below 16
  function automatic logic [6:0] mod_n(input logic [7:0] a, input logic [6:0] n);
    logic [7:0] r;
    r = a;
    for (int i = 0; i < LSL_MOD_ITER; i++) begin
      if (r >= {1'b0, n}) begin
        r = r - {1'b0, n};
      end
    end
    return r[6:0];
  endfunction

  function automatic logic [6:0] mux_rows(input logic [3:0] code);
    return 7'(16 + 8 * int'(code));
  endfunction

  assign icon_eff = icon_req_q & ext_q;
  // coarse step when icon row shown or display is partial
  assign step_mask = (icon_eff || (mux_q < LSL_MUX_FULL_LO)) ? LSL_STEP16_MASK :
                     LSL_STEP8_MASK;

  // bias variables chosen from the rate and the icon row state; software can only override p
  always_comb begin
    n_d = mux_rows(mux_q);
    m_d = 7'd81;
    p_d = 4'd8;
    if (!icon_eff) begin
      case (mux_q)
        4'd0: begin m_d = 7'd25; p_d = 4'd2; end
        4'd1: begin m_d = 7'd49; p_d = 4'd2; end
        4'd2: begin m_d = 7'd81; p_d = 4'd2; end
        4'd3: begin m_d = 7'd49; p_d = 4'd4; end
        4'd4: begin m_d = 7'd64; p_d = 4'd4; end
        4'd5: begin m_d = 7'd81; p_d = 4'd4; end
        4'd6: begin m_d = 7'd64; p_d = 4'd8; end
        default: begin m_d = 7'd81; p_d = 4'd8; end
      endcase
    end else begin
      case (mux_q)
        4'd0: begin n_d = 7'd24; m_d = 7'd49; p_d = 4'd2; end
        4'd2: begin n_d = 7'd40; m_d = 7'd49; p_d = 4'd4; end
        4'd4: begin n_d = 7'd56; m_d = 7'd81; p_d = 4'd8; end
        default: begin n_d = 7'd80; m_d = 7'd81; p_d = 4'd8; end
      endcase
    end
    // trading contrast for power is only offered at rates 1:64 and 1:80
    if (mp_en_q && (mux_q == LSL_MUX_FULL_LO || mux_q == LSL_MUX_MAX)) begin
      p_d = mp_sel_q ? 4'd8 : 4'd4;
    end
  end

  // apb decode
  assign wr_en = psel & penable & pready & pwrite;
  assign rd_setup = psel & ~penable;
  assign wdat_l = pwdata[6:0];
  assign wdat_mux = pwdata[LSL_MODE_MUX_LSB +: 4];
  assign wdat_icon = pwdata[LSL_MODE_ICON_BIT] & pwdata[LSL_MODE_EXT_BIT];
  assign start_bad = (wdat_l == LSL_LINE_BANNED) || ((wdat_l & ~step_mask) != 7'h00);
  assign irow_bad = icon_eff && (wdat_l == LSL_ICON_ROW);
  assign mode_bad = (wdat_mux > LSL_MUX_MAX) || (wdat_icon && wdat_mux[0]);
  assign mapped = (paddr == LSL_OFS_START) || (paddr == LSL_OFS_IROW) ||
                  (paddr == LSL_OFS_MODE) || (paddr == LSL_OFS_STAT) ||
                  (paddr == LSL_OFS_SCAN);

  always_comb begin
    rd_d = 32'h0000_0000;
    case (paddr)
      LSL_OFS_START: rd_d[6:0] = start_q;
      LSL_OFS_IROW: rd_d[6:0] = irow_q;
      LSL_OFS_MODE: begin
        rd_d[LSL_MODE_MUX_LSB +: 4] = mux_q;
        rd_d[LSL_MODE_ICON_BIT] = icon_req_q;
        rd_d[LSL_MODE_EXT_BIT] = ext_q;
        rd_d[LSL_MODE_MPEN_BIT] = mp_en_q;
        rd_d[LSL_MODE_MPSEL_BIT] = mp_sel_q;
      end
      LSL_OFS_STAT: begin
        rd_d[LSL_STAT_P_LSB +: 4] = mra_p_q;
        rd_d[LSL_STAT_M_LSB +: 7] = mra_m_q;
        rd_d[LSL_STAT_N_LSB +: 7] = mra_n_q;
        rd_d[LSL_STAT_ERR_LSB +: 3] = err_q;
      end
      LSL_OFS_SCAN: begin
        rd_d[LSL_SCAN_ROW_LSB +: 7] = drive_row_q;
        rd_d[LSL_SCAN_LINE_LSB +: 7] = ram_line_q;
      end
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // answer is registered in setup so every bus output is a flop
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= rd_setup;
      pslverr <= rd_setup & ~mapped;
      if (rd_setup) begin
        prdata <= rd_d;
      end
    end
  end

  // start line and initial row; illegal writes keep the old value
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      start_q <= LSL_RST_START;
      irow_q <= LSL_RST_IROW;
    end else begin
      if (wr_en && paddr == LSL_OFS_START && !start_bad) begin
        start_q <= wdat_l;
      end else if ((start_q & ~step_mask) != 7'h00) begin
        // a mode change can tighten the step; fall back to the coarser grid
        start_q <= start_q & step_mask;
      end
      if (wr_en && paddr == LSL_OFS_IROW && !irow_bad) begin
        irow_q <= wdat_l;
      end else if (icon_eff && irow_q == LSL_ICON_ROW) begin
        irow_q <= LSL_RST_IROW;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mux_q <= LSL_RST_MUX;
      icon_req_q <= 1'b0;
      ext_q <= 1'b0;
      mp_en_q <= 1'b0;
      mp_sel_q <= 1'b0;
    end else if (wr_en && paddr == LSL_OFS_MODE && !mode_bad) begin
      mux_q <= wdat_mux;
      icon_req_q <= pwdata[LSL_MODE_ICON_BIT];
      ext_q <= pwdata[LSL_MODE_EXT_BIT];
      mp_en_q <= pwdata[LSL_MODE_MPEN_BIT];
      mp_sel_q <= pwdata[LSL_MODE_MPSEL_BIT];
    end
  end

  // sticky refusal flags, write one to clear; a new refusal beats the clear
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      err_q <= 3'h0;
    end else begin
      err_q <= (err_q & ~((wr_en && paddr == LSL_OFS_STAT) ?
                pwdata[LSL_STAT_ERR_LSB +: 3] : 3'h0)) |
               {wr_en && paddr == LSL_OFS_MODE && mode_bad,
                wr_en && paddr == LSL_OFS_IROW && irow_bad,
                wr_en && paddr == LSL_OFS_START && start_bad};
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mra_p_q <= 4'd8;
      mra_m_q <= 7'd81;
      mra_n_q <= mux_rows(LSL_RST_MUX);
      icon_on_q <= 1'b0;
    end else begin
      mra_p_q <= p_d;
      mra_m_q <= m_d;
      mra_n_q <= n_d;
      icon_on_q <= icon_eff;
    end
  end

  // row scan; offsets are latched per frame so a mid-frame start line or initial row write cannot tear it
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      scan_k_q <= 7'h00;
      l_mod_q <= 7'h00;
      c_mod_q <= 7'h00;
      drive_row_q <= 7'h00;
      ram_line_q <= 7'h00;
      frame_start_q <= 1'b0;
    end else begin
      scan_k_q <= (scan_k_q + 7'd1 >= mra_n_q) ? 7'h00 : scan_k_q + 7'd1;
      if (scan_k_q == 7'h00) begin
        l_mod_q <= mod_n({1'b0, start_q}, mra_n_q);
        c_mod_q <= mod_n({1'b0, irow_q}, mra_n_q);
        // first driven row carries the start line itself
        drive_row_q <= mod_n({1'b0, irow_q}, mra_n_q);
        ram_line_q <= mod_n({1'b0, start_q}, mra_n_q);
      end else begin
        drive_row_q <= mod_n({1'b0, c_mod_q} + {1'b0, scan_k_q}, mra_n_q);
        ram_line_q <= mod_n({1'b0, l_mod_q} + {1'b0, scan_k_q}, mra_n_q);
      end
      frame_start_q <= (scan_k_q == 7'h00);
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_reset_done;
    $past(!rst_n) ##0 rst_n;
  endsequence
  sequence s_mode_settled;
    $stable({mux_q, icon_req_q, ext_q, mp_en_q, mp_sel_q})[*2];
  endsequence

  property p_reset_zero;
    s_reset_done |-> (start_q == 7'h00) && (irow_q == 7'h00);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("offsets not zero after reset");

  property p_step8;
    !icon_eff && (mux_q >= LSL_MUX_FULL_LO) |=> start_q[2:0] == 3'h0;
  endproperty
  a_step8: assert property (p_step8) else $error("start line off the 8 grid");

  property p_step16;
    (icon_eff || mux_q < LSL_MUX_FULL_LO) ##1 $stable(step_mask) |-> start_q[3:0] == 4'h0;
  endproperty
  a_step16: assert property (p_step16) else $error("start line off the 16 grid");

  property p_no72;
    start_q != LSL_LINE_BANNED;
  endproperty
  a_no72: assert property (p_no72) else $error("start line holds 72");

  property p_icon_row;
    icon_eff ##1 icon_eff |-> irow_q != LSL_ICON_ROW;
  endproperty
  a_icon_row: assert property (p_icon_row) else $error("initial row on icon row");

  property p_icon_ext;
    icon_on_q |-> $past(ext_q);
  endproperty
  a_icon_ext: assert property (p_icon_ext) else $error("icon row shown without ext set");

  property p_auto_low;
    s_mode_settled ##0 !icon_eff && mux_q == 4'd0 |-> mra_p_q == 4'd2 && mra_m_q == 7'd25;
  endproperty
  a_auto_low: assert property (p_auto_low) else $error("1:16 bias set wrong");

  property p_icon_16;
    s_mode_settled ##0 icon_eff && mux_q == 4'd0 |-> mra_n_q == 7'd24 && mra_p_q == 4'd2;
  endproperty
  a_icon_16: assert property (p_icon_16) else $error("icon 1:16 bias set wrong");

  property p_manual_p;
    s_mode_settled ##0 mp_en_q && mux_q == LSL_MUX_MAX && !mp_sel_q |-> mra_p_q == 4'd4;
  endproperty
  a_manual_p: assert property (p_manual_p) else $error("manual p ignored at 1:80");

  property p_manual_low;
    s_mode_settled ##0 mp_en_q && mp_sel_q && mux_q == 4'd4 && !icon_eff |-> mra_p_q == 4'd4;
  endproperty
  a_manual_low: assert property (p_manual_low) else $error("manual p used at low rate");

  property p_first_row;
    scan_k_q == 7'h00 && start_q < mra_n_q && irow_q < mra_n_q |=>
      ram_line_q == $past(start_q) && drive_row_q == $past(irow_q);
  endproperty
  a_first_row: assert property (p_first_row) else $error("first row line mismatch");

  property p_wrap;
    $stable(mra_n_q)[*2] |-> ram_line_q < mra_n_q && scan_k_q < mra_n_q;
  endproperty
  a_wrap: assert property (p_wrap) else $error("scan line beyond active rows");

  property p_top_rate;
    s_mode_settled ##0 !mp_en_q && mux_q == LSL_MUX_MAX |-> mra_p_q == 4'd8;
  endproperty
  a_top_rate: assert property (p_top_rate) else $error("p not eight at 1:80");

  property p_mode_refused;
    wr_en && paddr == LSL_OFS_MODE && mode_bad |=> $stable(mux_q) && err_q[2];
  endproperty
  a_mode_refused: assert property (p_mode_refused) else $error("bad mode write taken");
endmodule

//--- test_lsl_start_bias.sv
// Purpose: self-checking bench for the start line and bias selection block
// Assumes: zero wait state slave; the bench still waits on pready
// Notes: read results are queued and compared by a monitor
`timescale 1ns/1ps
module test_lsl_start_bias;
  import lsl_pkg::*;
  logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr, frame_start_q, icon_on_q;
  logic [7:0] paddr, frame_len, v, md;
  logic [31:0] pwdata, prdata;
  logic [6:0] drive_row_q, ram_line_q, mra_m_q, mra_n_q, first_row, first_line, sl;
  logic [3:0] mra_p_q;
  logic [32:0] eq[$];
  logic [31:0] mq[$];
  int err_count, tests_run, bad_cnt, seed, b0;
  int mtab[9] = '{25, 49, 81, 49, 64, 81, 64, 81, 81};
  int nic[5] = '{24, 40, 56, 80, 80};
  int mp[6] = '{'h46, 'h48, 'hC6, 'hC8, 'h42, 'hC4};
  int pe[6] = '{4, 4, 8, 8, 2, 4};
  int sm[9] = '{8, 8, 8, 8, 'h38, 'h38, 'h38, 2, 2};
  int sv[9] = '{8, 72, 12, 40, 24, 48, 72, 8, 16};

  lsl_start_bias DUT (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .drive_row_q, .ram_line_q, .frame_start_q, .icon_on_q, .mra_p_q,
    .mra_m_q, .mra_n_q);
  lsl_glass_model glass (.core_clk, .rst_n, .drive_row_q, .ram_line_q, .mra_n_q,
    .frame_start_q, .frame_len, .first_row, .first_line, .bad_cnt);

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task finish_test;
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      finish_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    // idle cycle lets derived values settle after a mode write
    @(posedge core_clk);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rd(input logic [7:0] a, input logic [32:0] e, input logic [31:0] m);
    eq.push_back(e);
    mq.push_back(m);
    apb(1'b0, a, 32'h0);
  endtask

  function logic [32:0] st(input int p, input int m, input int n);
    return {15'h0000, 7'(n), 7'(m), 4'(p)};
  endfunction

  function logic [6:0] msk(input logic [7:0] x);
    return ((x[4] && x[5]) || x[3:0] < LSL_MUX_FULL_LO) ? LSL_STEP16_MASK : LSL_STEP8_MASK;
  endfunction

  always @(posedge core_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      chk("read", {eq[0][32], eq[0][31:0] & mq[0]}, {pslverr, prdata & mq[0]});
      void'(eq.pop_front());
      void'(mq.pop_front());
    end
  end

  initial begin
    #100000;
    err_count++;
    finish_test();
  end

  initial begin
    seed = 65578;
    err_count = 0;
    tests_run = 0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sl = 7'h00;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(LSL_OFS_STAT, st(8, 81, 80), 32'h3FFFF);
    rd(LSL_OFS_START, 33'h0, 32'h7F);
    rd(LSL_OFS_IROW, 33'h0, 32'h7F);
    rd(8'h20, 33'h100000000, 32'hFFFFFFFF);
    for (int k = 0; k < 9; k++) begin
      wr(LSL_OFS_MODE, 32'(k));
      rd(LSL_OFS_STAT, st(k < 3 ? 2 : k < 6 ? 4 : 8, mtab[k], 16 + 8 * k), 32'h3FFFF);
    end
    for (int i = 0; i < 5; i++) begin
      wr(LSL_OFS_MODE, 32'(48 + 2 * i));
      rd(LSL_OFS_STAT, st(i < 1 ? 2 : i < 2 ? 4 : 8, i < 2 ? 49 : 81, nic[i]), 32'h3FFFF);
      chk("icon on", 33'h1, 33'(icon_on_q));
    end
    wr(LSL_OFS_MODE, 32'h10);
    rd(LSL_OFS_STAT, st(2, 25, 16), 32'h3FFFF);
    chk("icon on", 33'h0, 33'(icon_on_q));
    for (int i = 0; i < 6; i++) begin
      wr(LSL_OFS_MODE, 32'(mp[i]));
      rd(LSL_OFS_STAT, 33'(pe[i]), 32'hF);
    end
    for (int i = 0; i < 15; i++) begin
      md = i < 9 ? 8'(sm[i]) : 8'h08;
      v = 8'($random(seed));
      v = i < 9 ? 8'(sv[i]) : v[7] ? v & 8'h78 : v & 8'h7F;
      wr(LSL_OFS_MODE, 32'(md));
      sl = sl & msk(md);
      wr(LSL_OFS_START, 32'(v));
      if (v[6:0] != LSL_LINE_BANNED && (v[6:0] & ~msk(md)) == 7'h00) begin
        sl = v[6:0];
      end
      rd(LSL_OFS_START, 33'(sl), 32'h7F);
    end
    rd(LSL_OFS_STAT, 33'h01000000, 32'h01000000);
    wr(LSL_OFS_MODE, 32'h38);
    wr(LSL_OFS_IROW, 32'd79);
    rd(LSL_OFS_IROW, 33'h0, 32'h7F);
    rd(LSL_OFS_STAT, 33'h02000000, 32'h02000000);
    wr(LSL_OFS_MODE, 32'h08);
    wr(LSL_OFS_IROW, 32'd79);
    rd(LSL_OFS_IROW, 33'd79, 32'h7F);
    wr(LSL_OFS_MODE, 32'h38);
    rd(LSL_OFS_IROW, 33'h0, 32'h7F);
    // odd rate code with the icon row on has no table entry
    wr(LSL_OFS_MODE, 32'h39);
    rd(LSL_OFS_MODE, 33'h38, 32'hFF);
    rd(LSL_OFS_STAT, 33'h04000000, 32'h04000000);
    wr(LSL_OFS_STAT, 32'h07000000);
    rd(LSL_OFS_STAT, 33'h0, 32'h07000000);
    for (int i = 0; i < 2; i++) begin
      wr(LSL_OFS_MODE, i == 0 ? 32'h08 : 32'h02);
      wr(LSL_OFS_START, 32'd16);
      wr(LSL_OFS_IROW, 32'd5);
      repeat (100) @(posedge core_clk);
      b0 = bad_cnt;
      repeat (200) @(posedge core_clk);
      chk("frame length", i == 0 ? 33'd80 : 33'd32, 33'(frame_len));
      chk("first line", 33'd16, 33'(first_line));
      chk("first row", 33'd5, 33'(first_row));
      chk("line order", 33'(b0), 33'(bad_cnt));
    end
    // a second reset must bring the offsets back to zero
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(LSL_OFS_START, 33'h0, 32'h7F);
    rd(LSL_OFS_IROW, 33'h0, 32'h7F);
    rd(LSL_OFS_STAT, st(8, 81, 80), 32'h7FFFFFF);
    finish_test();
  end
endmodule
